/* hdl/swi_pkg.sv */
// swi_pkg: constants, field layout and bus carrier for the SYSREF window
// and identification register bank.
// assumes a byte-wide register port driven by the serial interface engine.
// Functional notes
// - The device-class register reads a fixed class code in bits 3-0, and its bits 7-4 are writable, reset to zero.
// - The family identification register is a fixed 16-bit read-only code that no write changes.
// - The silicon revision register is a fixed 8-bit read-only generation code.
// - The maker identification register is a fixed 16-bit read-only manufacturer code.
// - With the edge-processor enable set, each new SYSREF edge reaches the digital logic; with it clear, none does.
// - The receiver sleep bit resets to one, and clearing it powers up the receiver.
// - With accumulate enabled, every position seen near an edge since it was set stays one.
// - With accumulate disabled, each new edge replaces the status with that edge's positions alone.
// - The fine-resolution bit selects a finer status view and a smaller delay step.
// - A four-bit capture delay select, reset to zero, picks the SYSREF sampling delay.
// - The edge-position status is 20 read-only bits with bits 23-20 reading zero.
package swi_pkg;

    localparam int ADDR_W = 15;
    localparam int POS_W = 20;

    // byte addresses; multi-byte registers put their low byte first
    localparam logic [14:0] ADDR_DEVICE_CLASS = 15'h0003;
    localparam logic [14:0] ADDR_FAMILY_LO = 15'h0004;
    localparam logic [14:0] ADDR_FAMILY_HI = 15'h0005;
    localparam logic [14:0] ADDR_REVISION = 15'h0006;
    localparam logic [14:0] ADDR_MAKER_LO = 15'h000C;
    localparam logic [14:0] ADDR_MAKER_HI = 15'h000D;
    localparam logic [14:0] ADDR_CAPTURE_CTRL = 15'h0080;
    localparam logic [14:0] ADDR_POS_B0 = 15'h0090;
    localparam logic [14:0] ADDR_POS_B1 = 15'h0091;
    localparam logic [14:0] ADDR_POS_B2 = 15'h0092;

    // sync_capture_control field positions
    localparam int BIT_PROC_EN = 7;
    localparam int BIT_RECV_SLEEP = 6;
    localparam int BIT_ACCUM_EN = 5;
    localparam int BIT_FINE_RES = 4;
    localparam int DELAY_SEL_LSB = 0;
    localparam int DELAY_SEL_W = 4;

    localparam logic [7:0] CAPTURE_CTRL_RESET = 8'h40;
    localparam logic [3:0] CLASS_RSVD_RESET = 4'h0;
    localparam logic [19:0] POS_RESET = 20'h00000;

    typedef struct packed {
        logic [14:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } swi_req_s;

endpackage

/* hdl/swi_regs.sv */
// swi_regs: identification registers plus SYSREF capture-window control
// and edge-position capture.
// assumes sysref_in, window_taps and the register port are synchronous to
// clock; window_taps comes from the analog edge-window sampler.
`timescale 1ns/1ps
`default_nettype none

module swi_regs
    import swi_pkg::*;
#(
    // arbitrary neutral identity values
    parameter logic [3:0] CLASS_CODE = 4'hA,
    parameter logic [15:0] FAMILY_CODE = 16'h1234,
    parameter logic [7:0] REVISION_CODE = 8'h01,
    parameter logic [15:0] MAKER_CODE = 16'h00A5
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire swi_req_s req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic sysref_in,
    input wire logic [POS_W-1:0] window_taps,
    output logic sysref_edge,
    output logic receiver_power_up,
    output logic fine_resolution,
    output logic [DELAY_SEL_W-1:0] capture_delay_select
);

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0] ctrl;
    logic [3:0] class_rsvd;
    logic [POS_W-1:0] edge_position_status;
    logic sysref_q;
    logic accum_q;
    logic edge_processor_enable;
    logic receiver_sleep;
    logic accumulate_enable;
    logic new_edge;
    logic [POS_W-1:0] next_position;
    logic [7:0] next_rd_data;
    logic [23:0] pos_word;

    assign edge_processor_enable = ctrl[BIT_PROC_EN];
    assign receiver_sleep = ctrl[BIT_RECV_SLEEP];
    assign accumulate_enable = ctrl[BIT_ACCUM_EN];

    always_ff @(posedge clock)
    begin
        if (!nrst)
            ctrl <= CAPTURE_CTRL_RESET;
        else if (req.wr && req.addr == ADDR_CAPTURE_CTRL)
            ctrl <= req.wdata;
    end

    // upper nibble of the class register is plain storage
    always_ff @(posedge clock)
    begin
        if (!nrst)
            class_rsvd <= CLASS_RSVD_RESET;
        else if (req.wr && req.addr == ADDR_DEVICE_CLASS)
            class_rsvd <= req.wdata[7:4];
    end

    ////////////////////////////////////////////////////////////////////////
    // analog-side controls

    // the receiver only draws power once software clears sleep
    assign receiver_power_up = ~receiver_sleep;
    assign fine_resolution = ctrl[BIT_FINE_RES];
    assign capture_delay_select =
        ctrl[DELAY_SEL_LSB +: DELAY_SEL_W];

    ////////////////////////////////////////////////////////////////////////
    // edge processing

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            sysref_q <= 1'b0;
            accum_q <= 1'b0;
        end
        else
        begin
            sysref_q <= sysref_in;
            accum_q <= accumulate_enable;
        end
    end

    // edges seen while disabled are dropped, not queued
    assign new_edge = sysref_in & ~sysref_q & edge_processor_enable;

    always_ff @(posedge clock)
    begin
        if (!nrst)
            sysref_edge <= 1'b0;
        else
            sysref_edge <= new_edge;
    end

    always_comb
    begin
        next_position = edge_position_status;
        if (accumulate_enable && !accum_q)
        begin
            // arming accumulate restarts the history; an edge in the same
            // cycle still counts
            next_position = new_edge ? window_taps : POS_RESET;
        end
        else if (new_edge)
        begin
            if (accumulate_enable)
                next_position = edge_position_status | window_taps;
            else
                next_position = window_taps;
        end
    end

    // holds while the processor is off, since new_edge is gated by it, except that arming accumulate clears it
    always_ff @(posedge clock)
    begin
        if (!nrst)
            edge_position_status <= POS_RESET;
        else
            edge_position_status <= next_position;
    end

    ////////////////////////////////////////////////////////////////////////
    // read side

    assign pos_word = {4'h0, edge_position_status};

    always_comb
    begin
        next_rd_data = 8'h00;
        unique case (req.addr)
            ADDR_DEVICE_CLASS: next_rd_data = {class_rsvd, CLASS_CODE};
            ADDR_FAMILY_LO: next_rd_data = FAMILY_CODE[7:0];
            ADDR_FAMILY_HI: next_rd_data = FAMILY_CODE[15:8];
            ADDR_REVISION: next_rd_data = REVISION_CODE;
            ADDR_MAKER_LO: next_rd_data = MAKER_CODE[7:0];
            ADDR_MAKER_HI: next_rd_data = MAKER_CODE[15:8];
            ADDR_CAPTURE_CTRL: next_rd_data = ctrl;
            ADDR_POS_B0: next_rd_data = pos_word[7:0];
            ADDR_POS_B1: next_rd_data = pos_word[15:8];
            ADDR_POS_B2: next_rd_data = pos_word[23:16];
            default: next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= req.rd;
            if (req.rd)
                rd_data <= next_rd_data;
        end
    end

endmodule

`default_nettype wire

/* tb/swi_regs_properties.sv */
// swi_regs_properties: port checker for swi_regs.
// assumes it is bound onto each swi_regs instance.
`timescale 1ns/1ps
`default_nettype none
module swi_regs_chk
    import swi_pkg::*;
#(
    // arbitrary identity values, equal to the design defaults
    parameter logic [3:0] CLASS_CODE = 4'hA,
    parameter logic [15:0] FAMILY_CODE = 16'h1234,
    parameter logic [7:0] REVISION_CODE = 8'h01,
    parameter logic [15:0] MAKER_CODE = 16'h00A5
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire swi_req_s req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic sysref_in,
    input wire logic sysref_edge,
    input wire logic receiver_power_up,
    input wire logic fine_resolution,
    input wire logic [DELAY_SEL_W-1:0] capture_delay_select
);
default clocking dc @(posedge clock);
endclocking
default disable iff (!nrst);
chk_class_read: assert property (req.rd && req.addr == 15'h0003
    |=> rd_valid && rd_data[3:0] == CLASS_CODE) else $error("class");
chk_family_fixed: assert property (req.rd && req.addr == 15'h0005
    |=> rd_data == FAMILY_CODE[15:8]) else $error("family");
chk_revision_fixed: assert property (req.rd && req.addr == 15'h0006
    |=> rd_data == REVISION_CODE) else $error("revision");
chk_maker_fixed: assert property (req.rd && req.addr == 15'h000C
    |=> rd_data == MAKER_CODE[7:0]) else $error("maker");
chk_edge_cause: assert property (sysref_edge
    |-> $past(sysref_in) && !$past(sysref_in, 2)) else $error("edge");
chk_pos_top: assert property (req.rd && req.addr == 15'h0092
    |=> rd_data[7:4] == 4'h0) else $error("pos top");
chk_sleep_write: assert property (req.wr && req.addr == 15'h0080
    |=> receiver_power_up == !$past(req.wdata[6])) else $error("sleep");
chk_ctrl_fields: assert property (
    req.wr && req.addr == 15'h0080
    |=> fine_resolution == $past(req.wdata[4])
    && capture_delay_select == $past(req.wdata[3:0])) else $error("ctrl");
chk_reset_ctrl: assert property ($rose(nrst)
    |-> !receiver_power_up && capture_delay_select == 4'h0) else $error("rst");
cover property (sysref_edge);
cover property (req.wr && req.addr == 15'h0080);
cover property (rd_valid && rd_data != 8'h00);
endmodule
bind swi_regs swi_regs_chk #(.CLASS_CODE(CLASS_CODE),
    .FAMILY_CODE(FAMILY_CODE), .REVISION_CODE(REVISION_CODE),
    .MAKER_CODE(MAKER_CODE)) i_chk (.clock(clock), .nrst(nrst), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .sysref_in(sysref_in),
    .sysref_edge(sysref_edge), .receiver_power_up(receiver_power_up),
    .fine_resolution(fine_resolution),
    .capture_delay_select(capture_delay_select));
`default_nettype wire

/* tb/swi_sync_src.sv */
// swi_sync_src: SYSREF source with its edge-window taps.
// assumes pulse is called just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module swi_sync_src (
    input wire logic clock,
    output logic sysref_in,
    output logic [19:0] window_taps
);
initial sysref_in = 1'b0;
initial window_taps = 20'h00000;
task automatic pulse(logic [19:0] t);
    @(posedge clock) #1 sysref_in = 1'b1;
    window_taps = t;
    // taps mean nothing off the edge cycle, so show garbage there
    @(posedge clock) #1 window_taps = ~t;
    @(posedge clock) #1 sysref_in = 1'b0;
    @(posedge clock) #1 window_taps = t ^ 20'h5A5A5;
endtask
endmodule
`default_nettype wire

/* tb/swi_regs_tb_top.sv */
// swi_regs_tb_top: self-checking bench for the register bank.
// assumes swi_sync_src stands in for the SYSREF receiver side.
`timescale 1ns/1ps
`default_nettype none
module swi_regs_tb_top
    import swi_pkg::*;
;
logic clock;
logic nrst;
swi_req_s req;
logic [7:0] rd_data, b;
logic rd_valid, sysref_in, sysref_edge, rpu, fres;
logic [19:0] taps;
logic [3:0] dsel;
logic [23:0] p;
int fails = 0;
int cmp_count = 0;
always #5 clock = ~clock;
swi_regs i_dut (.clock(clock), .nrst(nrst), .req(req), .rd_data(rd_data),
    .rd_valid(rd_valid), .sysref_in(sysref_in), .window_taps(taps),
    .sysref_edge(sysref_edge), .receiver_power_up(rpu),
    .fine_resolution(fres), .capture_delay_select(dsel));
swi_sync_src i_src (.clock(clock), .sysref_in(sysref_in), .window_taps(taps));
int edge_count = 0;
// count on the falling edge, where the registered pulse has settled
always @(negedge clock)
begin
    if (sysref_edge === 1'b1)
        edge_count++;
end
////////////////////////////////////////////////////////////////////////////
task automatic cmp(string n, logic [23:0] e, logic [23:0] g);
    cmp_count++;
    fails += int'(g !== e);
    if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
endtask
task automatic wr(logic [14:0] a, logic [7:0] d);
    // start a clock edge after the previous release, never in its step
    @(posedge clock) #1 req = '{a, d, 1'b1, 1'b0};
    @(posedge clock) #1 req.wr = 1'b0;
endtask
task automatic rd(logic [14:0] a, output logic [7:0] d);
    @(posedge clock) #1 req = '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock) #1 req.rd = 1'b0;
    cmp("rd_valid", 24'h1, 24'(rd_valid));
    d = rd_data;
endtask
task automatic pos(logic [23:0] e);
    rd(ADDR_POS_B0, p[7:0]);
    rd(ADDR_POS_B1, p[15:8]);
    rd(ADDR_POS_B2, p[23:16]);
    cmp("pos", e, p);
endtask
task automatic t_ident;
    logic [14:0] ad[8] = '{15'h3, 15'h4, 15'h5, 15'h6, 15'hC, 15'hD,
        15'h80, 15'h7FFF};
    logic [7:0] ex[8] = '{8'hFA, 8'h34, 8'h12, 8'h01, 8'hA5, 8'h00, 8'h40,
        8'h00};
    rd(ADDR_DEVICE_CLASS, b);
    cmp("class", 24'h00000A, 24'(b));
    wr(ADDR_DEVICE_CLASS, 8'hF0);
    wr(ADDR_FAMILY_LO, 8'hFF);
    foreach (ad[i])
    begin
        rd(ad[i], b);
        cmp("ident", 24'(ex[i]), 24'(b));
    end
    cmp("power", 24'h0, 24'(rpu));
endtask
task automatic t_sync;
    wr(ADDR_CAPTURE_CTRL, 8'h00);
    cmp("power", 24'h1, 24'(rpu));
    i_src.pulse(20'h00F00);
    pos(24'h0);
    wr(ADDR_CAPTURE_CTRL, 8'h80);
    i_src.pulse(20'h00F00);
    pos(24'h00F00);
    i_src.pulse(20'h80001);
    pos(24'h80001);
    wr(ADDR_CAPTURE_CTRL, 8'hA0);
    i_src.pulse(20'h00030);
    i_src.pulse(20'h00100);
    pos(24'h00130);
    wr(ADDR_CAPTURE_CTRL, 8'h20);
    i_src.pulse(20'hFFFFF);
    pos(24'h00130);
    wr(ADDR_CAPTURE_CTRL, 8'h1B);
    cmp("fine", 24'h1, 24'(fres));
    cmp("dsel", 24'hB, 24'(dsel));
    wr(ADDR_CAPTURE_CTRL, 8'h40);
    cmp("power", 24'h0, 24'(rpu));
    cmp("edges", 24'h4, 24'(edge_count));
endtask
task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
initial
begin
    clock = 1'b0;
    nrst = 1'b0;
    req = '0;
    repeat (10) @(posedge clock);
    #1 nrst = 1'b1;
    t_ident;
    t_sync;
    close_out;
end
initial
begin
    #20000;
    fails++;
    close_out;
end
endmodule
`default_nettype wire
